//--- fsl_fan_loop.sv
// Fan speed loop: general configuration, ramp-limited drive and PWM output.
// Assumes byte register port and tach input synchronous to sys_clk.
// Function
// - Auto speed off by default; drive follows the software drive level.
// - Auto speed on: drive adjusted so measured tach tracks the target.
// - Range field scales tach counts by 1, 2, 4 or 8; default 01.
// - Edge field selects 3, 5, 7 or 9 tach edges per rotation.
// - Edge field resets to 01, five edges for a two-pole fan.
// - Mismatched edges scale reported speed by 0.5, 1, 1.5 or 2.
// - Update field picks 100 to 1600 ms drive update interval; default 400 ms.
// - Drive changes by at most the step once per update interval.
// - Ramp limit applies also with closed-loop regulation off.
// - Drive 00h is minimum duty, FFh maximum, linear between.
`include "fsl_defs.svh"
`default_nettype none

module fsl_fan_loop #(
    parameter int UNIT_CYCLES = `FSL_UPDATE_UNIT_MS * `FSL_CLK_KHZ,
    parameter int TACH_SHIFT  = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic [7:0]      regRdData,
    input  wire logic       tachIn,
    output logic            pwmOut
);

    localparam int TW = $clog2(UNIT_CYCLES + 1);

    fsl_pkg::fsl_cfg_s  cfg_q, cfg_d;
    logic [7:0]         driveSet_q, driveSet_d;
    logic [7:0]         step_q, step_d;
    logic [15:0]        target_q, target_d;
    logic [7:0]         drive_q, drive_d;
    logic [TW-1:0]      unitCnt_q, unitCnt_d;
    logic [4:0]         updCnt_q, updCnt_d;
    logic [7:0]         pwmCnt_q, pwmCnt_d;
    logic               pwmOut_q, pwmOut_d;
    logic [7:0]         rdData_q, rdData_d;
    fsl_pkg::fsl_tach_s tach;
    logic [15:0]        reading;
    logic               unitTick;
    logic               updateTick;
    logic [4:0]         unitsNeeded;
    logic [8:0]         upSum;
    logic [7:0]         driveUp;
    logic [7:0]         driveDown;

    // Update interval in 100 ms units
    function automatic logic [4:0] units_of(input logic [2:0] sel);
        case (sel)
            3'h0:    units_of = 5'h01;
            3'h1:    units_of = 5'h02;
            3'h2:    units_of = 5'h03;
            3'h3:    units_of = 5'h04;
            3'h4:    units_of = 5'h05;
            3'h5:    units_of = 5'h08;
            3'h6:    units_of = 5'h0C;
            default: units_of = 5'h10;
        endcase
    endfunction : units_of

    fsl_tach_meter #(
        .CNT_W (TACH_SHIFT + 16),
        .SHIFT (TACH_SHIFT)
    ) u_tach (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .tachIn    (tachIn),
        .edgeSel   (cfg_q.edgeSel),
        .tachRange (cfg_q.tachRange),
        .result    (tach)
    );

    logic [15:0] reading_q, reading_d;
    assign reading = reading_q;

    // Register writes and held tach reading
    always_comb begin
        cfg_d      = cfg_q;
        driveSet_d = driveSet_q;
        step_d     = step_q;
        target_d   = target_q;
        reading_d  = tach.done ? tach.count : reading_q;
        if (regWrEn) begin
            case (regAddr)
                `FSL_OFS_DRIVE:  if (!cfg_q.autoEn) driveSet_d = regWrData;
                `FSL_OFS_CFG:    cfg_d = fsl_pkg::fsl_cfg_s'(regWrData);
                `FSL_OFS_STEP:   step_d = regWrData;
                `FSL_OFS_TGT_LO: target_d[7:0] = regWrData;
                `FSL_OFS_TGT_HI: target_d[15:8] = regWrData;
                default:         ;
            endcase
        end
        // Leaving auto mode keeps the drive the loop last used
        if (cfg_q.autoEn && !cfg_d.autoEn) driveSet_d = drive_q;
    end

    // Update interval timer
    assign unitsNeeded = units_of(cfg_q.updateSel);
    assign unitTick    = (unitCnt_q == TW'(UNIT_CYCLES - 1));
    assign updateTick  = unitTick && (updCnt_q + 5'h01 >= unitsNeeded);
    always_comb begin
        unitCnt_d = unitTick ? '0 : unitCnt_q + 1'b1;
        updCnt_d  = updCnt_q;
        if (unitTick) updCnt_d = updateTick ? 5'h00 : updCnt_q + 5'h01;
    end

    // Step-limited drive ramp
    assign upSum     = {1'b0, drive_q} + {1'b0, step_q};
    assign driveUp   = upSum[8] ? `FSL_DRIVE_MAX : upSum[7:0];
    assign driveDown = (drive_q > step_q) ? drive_q - step_q : 8'h00;
    always_comb begin
        drive_d = drive_q;
        if (updateTick) begin
            if (cfg_q.autoEn) begin
                // Larger count means slower fan
                if (reading > target_q) drive_d = driveUp;
                else if (reading < target_q) drive_d = driveDown;
            end else begin
                if (driveSet_q > drive_q)
                    drive_d = (driveUp > driveSet_q) ? driveSet_q : driveUp;
                else if (driveSet_q < drive_q)
                    drive_d = (driveDown < driveSet_q) ? driveSet_q : driveDown;
            end
        end
    end

    // PWM over 255 slots, FFh stays high
    always_comb begin
        pwmCnt_d = (pwmCnt_q == 8'hFE) ? 8'h00 : pwmCnt_q + 8'h01;
        pwmOut_d = (pwmCnt_q < drive_q);
    end

    // Read mux
    always_comb begin
        rdData_d = rdData_q;
        if (regRdEn) begin
            case (regAddr)
                `FSL_OFS_DRIVE:  rdData_d = cfg_q.autoEn ? drive_q : driveSet_q;
                `FSL_OFS_CFG:    rdData_d = cfg_q;
                `FSL_OFS_STEP:   rdData_d = step_q;
                `FSL_OFS_TGT_LO: rdData_d = target_q[7:0];
                `FSL_OFS_TGT_HI: rdData_d = target_q[15:8];
                `FSL_OFS_RD_LO:  rdData_d = reading_q[7:0];
                `FSL_OFS_RD_HI:  rdData_d = reading_q[15:8];
                default:         rdData_d = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_q      <= fsl_pkg::fsl_cfg_s'(`FSL_CFG_RESET);
            driveSet_q <= `FSL_DRIVE_RESET;
            step_q     <= `FSL_STEP_RESET;
            target_q   <= `FSL_TGT_RESET;
            reading_q  <= `FSL_COUNT_MAX;
            drive_q    <= `FSL_DRIVE_RESET;
            unitCnt_q  <= '0;
            updCnt_q   <= 5'h00;
            pwmCnt_q   <= 8'h00;
            pwmOut_q   <= 1'b0;
            rdData_q   <= 8'h00;
        end else begin
            cfg_q      <= cfg_d;
            driveSet_q <= driveSet_d;
            step_q     <= step_d;
            target_q   <= target_d;
            reading_q  <= reading_d;
            drive_q    <= drive_d;
            unitCnt_q  <= unitCnt_d;
            updCnt_q   <= updCnt_d;
            pwmCnt_q   <= pwmCnt_d;
            pwmOut_q   <= pwmOut_d;
            rdData_q   <= rdData_d;
        end
    end

    assign pwmOut    = pwmOut_q;
    assign regRdData = rdData_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence manual_step_s;
        updateTick && !cfg_q.autoEn && driveSet_q > drive_q;
    endsequence
    sequence auto_slow_s;
        updateTick && cfg_q.autoEn && reading > target_q && drive_q != `FSL_DRIVE_MAX;
    endsequence

    ramp_bound_a: assert property (updateTick |=>
        (drive_q >= $past(drive_q) ? drive_q - $past(drive_q)
                                   : $past(drive_q) - drive_q) <= $past(step_q))
        else $error("drive moved more than one step");
    ramp_hold_a: assert property (!updateTick |=> $stable(drive_q))
        else $error("drive changed between updates");
    manual_rise_a: assert property (manual_step_s |=>
        drive_q > $past(drive_q) && drive_q <= $past(driveSet_q))
        else $error("manual drive did not approach setting");
    auto_rise_a: assert property (auto_slow_s |=> drive_q > $past(drive_q))
        else $error("auto loop did not raise drive for slow fan");
    auto_lock_a: assert property (cfg_q.autoEn && regWrEn && regAddr == `FSL_OFS_DRIVE
        |=> $stable(driveSet_q))
        else $error("drive level written during auto mode");
    cfg_reset_a: assert property ($past(srst) |-> cfg_q == `FSL_CFG_RESET)
        else $error("configuration not at default after reset");
    pwm_level_a: assert property (drive_q == `FSL_DRIVE_MAX |=> pwmOut)
        else $error("full drive did not hold output high");
    pwm_zero_a: assert property (drive_q == 8'h00 |=> !pwmOut)
        else $error("zero drive produced output pulse");
    update_space_a: assert property (updateTick |-> unitTick
        && updCnt_q + 5'h01 >= unitsNeeded)
        else $error("update taken at wrong interval");
    cfg_write_a: assert property (regWrEn && regAddr == `FSL_OFS_CFG
        |=> cfg_q == $past(regWrData))
        else $error("configuration write not stored");

endmodule : fsl_fan_loop

`default_nettype wire

//--- fsl_defs.svh
// Constants of the fan speed loop: register offsets, reset values, timing.
// Assumes byte-wide registers reached at the offsets below.
`ifndef FSL_DEFS_SVH
`define FSL_DEFS_SVH

`define FSL_OFS_DRIVE     8'h00
`define FSL_OFS_CFG       8'h02
`define FSL_OFS_STEP      8'h07
`define FSL_OFS_TGT_LO    8'h0C
`define FSL_OFS_TGT_HI    8'h0D
`define FSL_OFS_RD_LO     8'h0E
`define FSL_OFS_RD_HI     8'h0F

`define FSL_CFG_RESET     8'h2B
`define FSL_DRIVE_RESET   8'h00
`define FSL_STEP_RESET    8'h01
`define FSL_TGT_RESET     16'hFFFF
`define FSL_DRIVE_MAX     8'hFF
`define FSL_COUNT_MAX     16'hFFFF

`define FSL_CLK_KHZ       25000
`define FSL_UPDATE_UNIT_MS 100

`endif

//--- fsl_pkg.sv
// Types shared by the fan speed loop modules.
// Assumes nothing beyond the field layout of the general configuration byte.
`default_nettype none

package fsl_pkg;

    // General configuration byte, bit 7 down to bit 0
    typedef struct packed {
        logic       autoEn;
        logic [1:0] tachRange;
        logic [1:0] edgeSel;
        logic [2:0] updateSel;
    } fsl_cfg_s;

    // Result of one tach measurement
    typedef struct packed {
        logic [15:0] count;
        logic        done;
    } fsl_tach_s;

    typedef enum logic [1:0] {
        TACH_IDLE = 2'b00,
        TACH_MEAS = 2'b01
    } fsl_tach_e;

endpackage : fsl_pkg

`default_nettype wire

//--- fsl_tach_meter.sv
// Tach period meter: counts clock cycles across the chosen number of edges.
// Assumes tachIn is already synchronous to sys_clk.
`include "fsl_defs.svh"
`default_nettype none

module fsl_tach_meter #(
    parameter int CNT_W = 24,
    parameter int SHIFT = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             tachIn,
    input  wire logic [1:0]       edgeSel,
    input  wire logic [1:0]       tachRange,
    output fsl_pkg::fsl_tach_s    result
);

    fsl_pkg::fsl_tach_e state_q, state_d;
    logic [CNT_W-1:0]   cycles_q, cycles_d;
    logic [3:0]         edges_q, edges_d;
    logic               tachPrev_q;
    fsl_pkg::fsl_tach_s result_q, result_d;
    logic               tachEdge;
    logic [3:0]         edgesNeeded;
    logic [19:0]        scaled;

    assign tachEdge    = tachIn ^ tachPrev_q;
    assign edgesNeeded = {1'b0, edgeSel, 1'b0} + 4'h3;
    // Range multiplier of 1, 2, 4 or 8 applied to the count
    assign scaled = {4'h0, cycles_q[SHIFT +: 16]} << tachRange;

    // Next state of the measurement
    always_comb begin
        state_d       = state_q;
        cycles_d      = cycles_q;
        edges_d       = edges_q;
        result_d      = result_q;
        result_d.done = 1'b0;
        case (state_q)
            fsl_pkg::TACH_IDLE: begin
                if (tachEdge) begin
                    state_d  = fsl_pkg::TACH_MEAS;
                    cycles_d = CNT_W'(1);
                    edges_d  = 4'h1;
                end
            end
            fsl_pkg::TACH_MEAS: begin
                if (tachEdge && (edges_q + 4'h1 == edgesNeeded)) begin
                    // Edge count mismatch with fan poles shifts reading
                    result_d.count = (scaled > 20'h0FFFF) ? `FSL_COUNT_MAX
                                                         : scaled[15:0];
                    result_d.done  = 1'b1;
                    cycles_d       = CNT_W'(1);
                    edges_d        = 4'h1;
                end else if (edges_q >= edgesNeeded) begin
                    // Edge field shrank mid-measurement, drop this one
                    state_d = fsl_pkg::TACH_IDLE;
                end else if (&cycles_q) begin
                    // Stalled fan reads as slowest speed
                    result_d.count = `FSL_COUNT_MAX;
                    result_d.done  = 1'b1;
                    state_d        = fsl_pkg::TACH_IDLE;
                end else begin
                    cycles_d = cycles_q + 1'b1;
                    edges_d  = edges_q + {3'h0, tachEdge};
                end
            end
            default: state_d = fsl_pkg::TACH_IDLE;
        endcase
    end

    // Measurement registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q    <= fsl_pkg::TACH_IDLE;
            cycles_q   <= '0;
            edges_q    <= 4'h0;
            tachPrev_q <= tachIn;   // No false edge when the pin idles high
            result_q   <= '{count: `FSL_COUNT_MAX, done: 1'b0};
        end else begin
            state_q    <= state_d;
            cycles_q   <= cycles_d;
            edges_q    <= edges_d;
            tachPrev_q <= tachIn;
            result_q   <= result_d;
        end
    end

    assign result = result_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    tach_edges_a: assert property (result.done && $past(state_q) == fsl_pkg::TACH_MEAS
        && !$past(&cycles_q) |-> $past(edges_q) + 4'h1 == $past(edgesNeeded))
        else $error("tach result taken at wrong edge count");
    tach_scale_a: assert property (result.done && $past(tachEdge) && !$past(&cycles_q)
        && $past(scaled) <= 20'h0FFFF |-> result.count == $past(scaled[15:0]))
        else $error("tach count not scaled by range multiplier");

endmodule : fsl_tach_meter

`default_nettype wire

//--- fsl_fan_model.sv
// Fan model: a free-spinning fan whose tach line toggles every halfPer clocks.
// Assumes the bench holds halfPer at 2 or more and changes it only between measurements.
`default_nettype none

module fsl_fan_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] halfPer,
    output logic            tachOut
);
    timeunit 1ns;
    timeprecision 1ns;

    int   cnt   = 0;
    logic level = 1'b0;

    // Tach square wave, both edges are counted by the block
    always @(posedge sys_clk) begin
        if (cnt + 1 >= int'(halfPer)) begin
            cnt <= 0;
            level <= ~level;
        end else begin
            cnt <= cnt + 1;
        end
    end

    assign tachOut = level;
endmodule : fsl_fan_model

`default_nettype wire

//--- test_fan_speed_loop_config.sv
// Bench for the fan loop: register defaults, tach readings, ramp and regulation.
// Assumes fsl_fan_loop and fsl_fan_model are compiled before it.
`include "fsl_defs.svh"
`default_nettype none

module test_fan_speed_loop_config;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int UNIT = 50;
    logic       sys_clk   = 1'b0;
    logic       srst      = 1'b1;
    logic [7:0] regAddr   = 8'h00;
    logic       regWrEn   = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic       regRdEn   = 1'b0;
    logic [7:0] regRdData;
    logic       tachIn;
    logic       pwmOut;
    logic [7:0] halfPer   = 8'h10;
    int         n_mismatch = 0;
    int         cmp_count  = 0;
    int         seed       = 32'h753F;
    int         unitTab[8] = '{1, 2, 3, 4, 5, 8, 12, 16};

    always #20 sys_clk = ~sys_clk;

    fsl_fan_loop #(.UNIT_CYCLES(UNIT), .TACH_SHIFT(0)) DUT (
        .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .tachIn(tachIn), .pwmOut(pwmOut));

    fsl_fan_model FAN (.sys_clk(sys_clk), .halfPer(halfPer), .tachOut(tachIn));

    // Reading expected from edge and range codes, no prescale
    function automatic logic [15:0] expRead(int ec, int rc, int h);
        int c;
        c = ((2 + 2 * ec) * h) << rc;
        return (c > 65535) ? 16'hFFFF : 16'(c);
    endfunction : expRead

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        @(posedge sys_clk);
        #1 d = regRdData;
    endtask : rd

    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        logic [7:0] l;
        logic [7:0] h;
        rd(a, l);
        rd(a + 8'h01, h);
        d = {h, l};
    endtask : rd16

    // High cycles over one full PWM frame length
    task automatic duty(output logic [15:0] n);
        n = 16'h0000;
        repeat (255) begin
            @(posedge sys_clk);
            #1 if (pwmOut === 1'b1) n = n + 16'h0001;
        end
    endtask : duty

    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic chkIn(input string nm, input int lo, input int hi, input logic [15:0] got);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, got);
        end
    endtask : chkIn

    task automatic doReset();
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
    endtask : doReset

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up();
    end

    // Main sequence
    initial begin
        logic [7:0]  b;
        logic [7:0]  w;
        logic [15:0] v;
        doReset();
        repeat (4) begin
            w = 8'($random(seed));
            wr(`FSL_OFS_CFG, w);
            rd(`FSL_OFS_CFG, b);
            chk("cfg rw", 16'(w), 16'(b));
        end
        doReset();
        rd(`FSL_OFS_CFG, b);
        chk("cfg reset", 16'h002B, 16'(b));
        rd(`FSL_OFS_DRIVE, b);
        chk("drive reset", 16'h0000, 16'(b));
        rd(8'h05, b);
        chk("unmapped", 16'h0000, 16'(b));
        duty(v);
        chk("duty 00", 16'h0000, v);
        // Every edge and range code against a random tach rate
        for (int ec = 0; ec < 4; ec++) begin
            for (int rc = 0; rc < 4; rc++) begin
                wr(`FSL_OFS_CFG, {1'b0, 2'(rc), 2'(ec), 3'b011});
                halfPer <= 8'(8 + ($random(seed) & 31));
                repeat (3 * (3 + 2 * ec) * 40 + 20) @(posedge sys_clk);
                rd16(`FSL_OFS_RD_LO, v);
                chk("tach reading", expRead(ec, rc, int'(halfPer)), v);
            end
        end
        // Manual drive ramps by one step per update
        wr(`FSL_OFS_CFG, 8'h28);
        wr(`FSL_OFS_DRIVE, 8'h40);
        duty(v);
        chkIn("ramp duty", 0, 7, v);
        repeat (70 * UNIT) @(posedge sys_clk);
        duty(v);
        chk("duty 40", 16'h0040, v);
        wr(`FSL_OFS_STEP, 8'hFF);
        wr(`FSL_OFS_DRIVE, 8'hFF);
        repeat (UNIT + 260) @(posedge sys_clk);
        duty(v);
        chk("duty FF", 16'h00FF, v);
        // Closed loop climbs one step per update for each update code
        wr(`FSL_OFS_TGT_LO, 8'h00);
        wr(`FSL_OFS_TGT_HI, 8'h00);
        for (int uc = 0; uc < 8; uc++) begin
            wr(`FSL_OFS_CFG, {5'b00101, 3'(uc)});
            wr(`FSL_OFS_STEP, 8'hFF);
            wr(`FSL_OFS_DRIVE, 8'h00);
            repeat ((2 * unitTab[uc] + 1) * UNIT) @(posedge sys_clk);
            wr(`FSL_OFS_STEP, 8'h01);
            wr(`FSL_OFS_CFG, {5'b10101, 3'(uc)});
            repeat (6 * unitTab[uc] * UNIT) @(posedge sys_clk);
            rd(`FSL_OFS_DRIVE, b);
            chkIn("update ticks", 5, 7, 16'(b));
        end
        // Nine edges on a two-pole fan: target doubled, slow speed wanted
        v = 16'h7FFF * 16'h0002;
        wr(`FSL_OFS_TGT_LO, v[7:0]);
        wr(`FSL_OFS_TGT_HI, v[15:8]);
        wr(`FSL_OFS_CFG, 8'hB8);
        repeat (12 * UNIT) @(posedge sys_clk);
        wr(`FSL_OFS_DRIVE, 8'h77);
        rd(`FSL_OFS_DRIVE, b);
        chk("auto down", 16'h0000, 16'(b));
        wrap_up();
    end
endmodule : test_fan_speed_loop_config

`default_nettype wire
